// [src/spisf_pkg.sv]
/*
  Constants for the serial port FIFO status block: offsets, field positions,
  reset value and timing counts.
  Assumes a 200 MHz pclk that also serves as the engine clock.
*/
`default_nettype none
package spisf_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FCTL = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h18;
  localparam logic [7:0] ADDR_TXD  = 8'h20;
  localparam logic [7:0] ADDR_RXD  = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_EN      = 0;   // ctrl: engine_enable
  localparam int B_MST     = 1;   // ctrl: master mode
  localparam int B_TX_LEVEL_SETTING    = 28;  // fctl: tx_level_setting lsb
  localparam int B_RX_LEVEL_SETTING    = 24;  // fctl: rx_level_setting lsb
  localparam int B_TXFL    = 1;   // fctl: tx_fifo_flush
  localparam int B_RXFL    = 0;   // fctl: rx_fifo_flush
  localparam int B_TX_FIFO_LEVEL   = 28;
  localparam int B_RX_FIFO_LEVEL   = 24;
  localparam int B_CLRP    = 23;
  localparam int B_UNDR    = 19;
  localparam int B_TXLV    = 18;
  localparam int B_TXFU    = 17;
  localparam int B_TXEM    = 16;
  localparam int B_ENS     = 15;
  localparam int B_RXTO    = 12;
  localparam int B_RXOV    = 11;
  localparam int B_RXLV    = 10;
  localparam int B_RXFU    = 9;
  localparam int B_RXEM    = 8;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [31:0] STAT_RST = 32'h0005_0110;
  localparam logic [31:0] IRQ_BITS = 32'h000c_1c00;

  // ----------------------------------------------------------------
  // Timing counts (engine clock is pclk)
  // ----------------------------------------------------------------
  localparam int FLUSH_SYS_CLK = 3;
  localparam int FLUSH_ENG_CLK = 3;
  localparam int FLUSH_CYC     = FLUSH_SYS_CLK + FLUSH_ENG_CLK;
  localparam int TO_MST_SCLK   = 64;
  localparam int TO_SLV_ENG    = 576;

  // Flush sequencer states
  typedef enum logic [1:0] {
    FL_IDLE = 2'b01,
    FL_BUSY = 2'b10
  } spisf_fl_type;

endpackage : spisf_pkg
`default_nettype wire

// [src/spisf_eng_if.sv]
/*
  Link between the status core and the serial shift engine.
  Assumes both ends run on pclk.
*/
`default_nettype none
interface spisf_eng_if #(parameter int W = 8);
  logic         en;
  logic         flush;
  logic         tx_valid;
  logic [W-1:0] tx_data;
  logic         tx_pop;
  logic         rx_push;
  logic [W-1:0] rx_data;
  logic         underrun;
  logic         sclk_rise;

  modport core (output en, flush, tx_valid, tx_data,
                input  tx_pop, rx_push, rx_data, underrun, sclk_rise);
  modport eng  (input  en, flush, tx_valid, tx_data,
                output tx_pop, rx_push, rx_data, underrun, sclk_rise);
endinterface : spisf_eng_if
`default_nettype wire

// [src/spisf_shifter.sv]
/*
  Serial shift engine: samples the peer's serial clock, shifts words in
  and out, MSB first. Assumes sclk and sdi are asynchronous pins.
*/
`default_nettype none
module spisf_shifter #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Pins
  input  wire logic sclk_pin,
  input  wire logic sdi_pin,
  output logic      sdo,
  // Core side
  spisf_eng_if.eng  eif
);

  logic         sck_s1_r, sck_s2_r, sck_d_r;
  logic         sdi_s1_r, sdi_s2_r;
  logic [3:0]   bit_r;
  logic [W-1:0] txsh_r;
  logic [W-1:0] rxsh_r;
  logic         rise, fall;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_d_r  <= 1'b0;
      sdi_s1_r <= 1'b0;
      sdi_s2_r <= 1'b0;
    end else if (ce) begin
      sck_s1_r <= sclk_pin;
      sck_s2_r <= sck_s1_r;
      sck_d_r  <= sck_s2_r;
      sdi_s1_r <= sdi_pin;
      sdi_s2_r <= sdi_s1_r;
    end
  end

  // Edge detect on the synchronised clock
  assign rise          = sck_s2_r & ~sck_d_r;
  assign fall          = ~sck_s2_r & sck_d_r;
  assign eif.sclk_rise = rise & ce;

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_r        <= 4'h0;
      txsh_r       <= '0;
      rxsh_r       <= '0;
      sdo          <= 1'b0;
      eif.tx_pop   <= 1'b0;
      eif.rx_push  <= 1'b0;
      eif.rx_data  <= '0;
      eif.underrun <= 1'b0;
    end else if (ce) begin
      eif.tx_pop   <= 1'b0;
      eif.rx_push  <= 1'b0;
      eif.underrun <= 1'b0;
      if (eif.flush || !eif.en) begin
        bit_r <= 4'h0;
      end else if (rise) begin
        rxsh_r <= {rxsh_r[W-2:0], sdi_s2_r};
        if (bit_r == 4'h0) begin
          if (eif.tx_valid) begin
            sdo        <= eif.tx_data[W-1];
            txsh_r     <= {eif.tx_data[W-2:0], 1'b0};
            eif.tx_pop <= 1'b1;
          end else begin
            eif.underrun <= 1'b1; // Hold last bit
            txsh_r       <= {W{sdo}}; // Later falls repeat it
          end
        end
        if (bit_r == 4'(W-1)) begin
          bit_r       <= 4'h0;
          eif.rx_push <= 1'b1;
          eif.rx_data <= {rxsh_r[W-2:0], sdi_s2_r};
        end else begin
          bit_r <= bit_r + 4'h1;
        end
      end else if (fall && bit_r != 4'h0) begin
        sdo    <= txsh_r[W-1];
        txsh_r <= {txsh_r[W-2:0], 1'b0};
      end
    end
  end

endmodule : spisf_shifter
`default_nettype wire

// [src/spisf_top.sv]
/*
  Serial port FIFO status block: APB register file, transmit and receive
  FIFOs, sticky event flags, flush sequencer and interrupt.
  Assumes an APB master on pclk and an external serial clock peer.
*/
`default_nettype none
module spisf_top
  import spisf_pkg::*;
#(
  parameter int DEPTH  = 4,
  parameter int W      = 8,
  parameter int TO_SLV = TO_SLV_ENG
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Serial pins
  input  wire logic        sclk_pin,
  input  wire logic        sdi_pin,
  output logic             sdo
);

  localparam int AW = $clog2(DEPTH);

  // Full test, used for both FIFOs
  function automatic logic is_full(input logic [3:0] c);
    is_full = (c == 4'(DEPTH));
  endfunction : is_full

  spisf_eng_if #(.W(W)) eif ();

  logic [1:0]   ctrl_r;
  logic [1:0]   tx_level_setting_r, rx_level_setting_r;
  logic [1:0]   flush_r;
  logic [31:0]  mask_r;
  logic [2:0]   fl_cnt_r;
  spisf_fl_type fl_state_r;
  logic         en_s1_r, en_s2_r;
  logic [W-1:0] tx_mem [DEPTH];
  logic [W-1:0] rx_mem [DEPTH];
  logic [AW-1:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic [3:0]   tx_cnt_r, rx_cnt_r;
  logic [9:0]   to_cnt_r;
  logic [2:0]   sticky_r;
  logic [31:0]  stat_raw;
  logic [31:0]  stat_snap_r;
  logic         setup, wr, rd, mapped;
  logic         tx_push, tx_pop, rx_push, rx_pop;
  logic         fl_start, to_tick, to_ev, ovf_ev;
  logic [9:0]   to_lim;
  logic [2:0]   ev, clr;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pready & pwrite;
  assign rd     = psel & penable & pready & ~pwrite;
  assign mapped = paddr == ADDR_CTRL || paddr == ADDR_FCTL || paddr == ADDR_STAT
                  || paddr == ADDR_MASK || paddr == ADDR_TXD || paddr == ADDR_RXD;

  // Answer one cycle after setup, read data latched in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite) begin
        case (paddr)
          ADDR_CTRL: prdata <= {30'h0, ctrl_r};
          ADDR_FCTL: prdata <= {2'h0, tx_level_setting_r, 2'h0, rx_level_setting_r, 22'h0, flush_r};
          ADDR_STAT: prdata <= stat_snap_r;
          ADDR_MASK: prdata <= mask_r;
          ADDR_RXD:  prdata <= 32'(rx_mem[rx_rp_r]);
          default:   prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Control, threshold and mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 2'h0;
      tx_level_setting_r <= 2'h0;
      rx_level_setting_r <= 2'h0;
      mask_r <= 32'h0000_0000;
    end else if (ce && wr) begin
      if (paddr == ADDR_CTRL) ctrl_r <= pwdata[1:0];
      if (paddr == ADDR_MASK) mask_r <= pwdata & IRQ_BITS;
      if (paddr == ADDR_FCTL) begin
        tx_level_setting_r <= pwdata[B_TX_LEVEL_SETTING+:2];
        rx_level_setting_r <= pwdata[B_RX_LEVEL_SETTING+:2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Flush sequencer
  // ----------------------------------------------------------------
  assign fl_start = (fl_state_r == FL_IDLE) && (flush_r != 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flush_r    <= 2'h0;
      fl_cnt_r   <= 3'h0;
      fl_state_r <= FL_IDLE;
    end else if (ce) begin
      case (fl_state_r)
        FL_IDLE: begin
          fl_cnt_r <= 3'h0;
          if (flush_r != 2'h0) fl_state_r <= FL_BUSY;
        end
        FL_BUSY: begin
          fl_cnt_r <= fl_cnt_r + 3'h1;
          if (fl_cnt_r == 3'(FLUSH_CYC - 2)) begin // Pending ends here
            flush_r    <= 2'h0;
            fl_state_r <= FL_IDLE;
          end
        end
        default: fl_state_r <= FL_IDLE;
      endcase
      if (wr && paddr == ADDR_FCTL && fl_state_r == FL_IDLE) begin
        flush_r <= flush_r | pwdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Enable crossing into the engine side
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
    end else if (ce) begin
      en_s1_r <= ctrl_r[B_EN];
      en_s2_r <= en_s1_r; // Seen by engine and status
    end
  end

  assign eif.en       = en_s2_r;
  assign eif.flush    = fl_state_r != FL_IDLE;
  assign eif.tx_valid = tx_cnt_r != 4'h0;
  assign eif.tx_data  = tx_mem[tx_rp_r];

  // ----------------------------------------------------------------
  // Transmit FIFO
  // ----------------------------------------------------------------
  assign tx_push = wr && paddr == ADDR_TXD && !is_full(tx_cnt_r);
  assign tx_pop  = eif.tx_pop && tx_cnt_r != 4'h0;

  always_ff @(posedge pclk) begin
    if (ce && tx_push) tx_mem[tx_wp_r] <= pwdata[W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp_r  <= '0;
      tx_rp_r  <= '0;
      tx_cnt_r <= 4'h0;
    end else if (ce) begin
      if (fl_start && flush_r[B_TXFL]) begin
        tx_wp_r  <= '0;
        tx_rp_r  <= '0;
        tx_cnt_r <= 4'h0;
      end else begin
        if (tx_push) tx_wp_r <= tx_wp_r + AW'(1);
        if (tx_pop)  tx_rp_r <= tx_rp_r + AW'(1);
        tx_cnt_r <= tx_cnt_r + 4'(tx_push) - 4'(tx_pop);
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive FIFO
  // ----------------------------------------------------------------
  assign rx_push = eif.rx_push && !is_full(rx_cnt_r);
  assign ovf_ev  = eif.rx_push && is_full(rx_cnt_r); // Word dropped
  assign rx_pop  = rd && paddr == ADDR_RXD && rx_cnt_r != 4'h0;

  always_ff @(posedge pclk) begin
    if (ce && rx_push) rx_mem[rx_wp_r] <= eif.rx_data;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wp_r  <= '0;
      rx_rp_r  <= '0;
      rx_cnt_r <= 4'h0;
    end else if (ce) begin
      if (fl_start && flush_r[B_RXFL]) begin
        rx_wp_r  <= '0;
        rx_rp_r  <= '0;
        rx_cnt_r <= 4'h0;
      end else begin
        if (rx_push) rx_wp_r <= rx_wp_r + AW'(1);
        if (rx_pop)  rx_rp_r <= rx_rp_r + AW'(1);
        rx_cnt_r <= rx_cnt_r + 4'(rx_push) - 4'(rx_pop);
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive time-out counter
  // ----------------------------------------------------------------
  assign to_tick = ctrl_r[B_MST] ? eif.sclk_rise : 1'b1;
  assign to_lim  = ctrl_r[B_MST] ? 10'(TO_MST_SCLK) : 10'(TO_SLV);
  assign to_ev   = to_tick && to_cnt_r == to_lim && rx_cnt_r != 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_cnt_r <= 10'h000;
    end else if (ce) begin
      if (rx_cnt_r == 4'h0 || rx_pop) begin
        to_cnt_r <= 10'h000;
      end else if (to_tick && to_cnt_r <= to_lim) begin
        to_cnt_r <= to_cnt_r + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags: underrun, time-out, overflow; set beats clear
  // ----------------------------------------------------------------
  assign ev  = {eif.underrun, to_ev, ovf_ev};
  assign clr = {wr && paddr == ADDR_STAT && pwdata[B_UNDR],
                (wr && paddr == ADDR_STAT && pwdata[B_RXTO]) || rx_pop,
                wr && paddr == ADDR_STAT && pwdata[B_RXOV]};

  generate
    for (genvar i = 0; i < 3; i++) begin : g_sticky
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sticky_r[i] <= 1'b0;
        end else if (ce) begin
          sticky_r[i] <= ev[i] | (sticky_r[i] & ~clr[i]);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status word and its read snapshot
  // ----------------------------------------------------------------
  always_comb begin
    stat_raw          = STAT_RST & 32'h0000_00ff; // Low byte keeps its reset level
    stat_raw[B_TX_FIFO_LEVEL+:4] = tx_cnt_r;
    stat_raw[B_RX_FIFO_LEVEL+:4] = rx_cnt_r;
    stat_raw[B_CLRP]  = flush_r != 2'h0;
    stat_raw[B_UNDR]  = sticky_r[2];
    stat_raw[B_TXLV]  = tx_cnt_r <= {2'h0, tx_level_setting_r} + 4'h1;
    stat_raw[B_TXFU]  = is_full(tx_cnt_r);
    stat_raw[B_TXEM]  = tx_cnt_r == 4'h0;
    stat_raw[B_ENS]   = en_s2_r;
    stat_raw[B_RXTO]  = sticky_r[1];
    stat_raw[B_RXOV]  = sticky_r[0];
    stat_raw[B_RXLV]  = rx_cnt_r > {2'h0, rx_level_setting_r} + 4'h1;
    stat_raw[B_RXFU]  = is_full(rx_cnt_r);
    stat_raw[B_RXEM]  = rx_cnt_r == 4'h0;
  end

  // Registered copy so reads never see a count mid-change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_snap_r <= STAT_RST;
    end else if (ce) begin
      stat_snap_r <= stat_raw;
    end
  end

  // Level interrupt from unmasked status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(stat_raw & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  spisf_shifter #(.W(W)) u_shifter (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .sclk_pin (sclk_pin),
    .sdi_pin  (sdi_pin),
    .sdo      (sdo),
    .eif      (eif)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_tx_count_field: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ce) |-> stat_snap_r[B_TX_FIFO_LEVEL+:4] == $past(tx_cnt_r))
    else $error("tx count field wrong");
  a_rx_count_field: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ce) |-> stat_snap_r[B_RX_FIFO_LEVEL+:4] == $past(rx_cnt_r))
    else $error("rx count field wrong");
  a_flush_done: assert property (@(posedge pclk) disable iff (!presetn)
    ce && fl_start |=> (flush_r != 2'h0) ##[1:40] (flush_r == 2'h0))
    else $error("flush pending stuck");
  a_underrun_set: assert property (@(posedge pclk) disable iff (!presetn)
    ce && eif.underrun |=> sticky_r[2] ##1 stat_snap_r[B_UNDR] || !$past(ce))
    else $error("underrun not flagged");
  a_tx_level_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ce) |-> stat_snap_r[B_TXLV] == ($past(tx_cnt_r) <= 4'($past(tx_level_setting_r)) + 4'h1))
    else $error("tx level flag wrong");
  a_irq_tx_level: assert property (@(posedge pclk) disable iff (!presetn)
    ce && stat_raw[B_TXLV] && mask_r[B_TXLV] |=> irq)
    else $error("tx level irq missing");
  a_tx_full_ind: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ce) |-> stat_snap_r[B_TXFU] == ($past(tx_cnt_r) == 4'(DEPTH)))
    else $error("tx full wrong");
  a_tx_empty_ind: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ce) |-> stat_snap_r[B_TXEM] == ($past(tx_cnt_r) == 4'h0))
    else $error("tx empty wrong");
  a_timeout_set: assert property (@(posedge pclk) disable iff (!presetn)
    ce && to_ev |=> sticky_r[1])
    else $error("timeout not flagged");
  a_timeout_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ce && rx_pop && !to_ev |=> !sticky_r[1])
    else $error("timeout not cleared by read");
  a_overflow_set: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ovf_ev && !fl_start |=> sticky_r[0] && rx_cnt_r == 4'(DEPTH) - 4'($past(rx_pop)))
    else $error("overflow not flagged");
  a_rx_level_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ce) |-> stat_snap_r[B_RXLV] == ($past(rx_cnt_r) > 4'($past(rx_level_setting_r)) + 4'h1))
    else $error("rx level flag wrong");

endmodule : spisf_top
`default_nettype wire

// [test/spisf_peer.sv]
/*
  Serial peer model: makes the link clock, drives data in, samples data out.
  Assumes the device samples data in on rising link clock edges.
*/
`default_nettype none
module spisf_peer (
  // Link pins
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle link: clock stands low
  initial begin
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  // One word, MSB first, 48 ns link period
  task automatic xfer(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sdi = d[i];
      #24 sclk = 1'b1;
      #24 r[i] = sdo;
      sclk = 1'b0;
    end
    sdi = ~d[0]; // Released line shows no stale bit
  endtask : xfer
endmodule : spisf_peer
`default_nettype wire

// [test/tb_spisf_top.sv]
/*
  Self-checking bench for the serial port FIFO status block.
  Assumes pclk also serves as engine clock; spisf_peer drives the link.
*/
`default_nettype none
module tb_spisf_top
  import spisf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, sclk, sdi, sdo;
  logic [64:0] ent;
  logic [64:0] expq[$];
  logic [7:0]  txq[$], rxq[$], q;
  int          n_mismatch = 0;
  int          checked = 0;

  spisf_top #(.TO_SLV(20)) dut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .sclk_pin(sclk),
    .sdi_pin(sdi), .sdo(sdo));
  spisf_peer peer (.sclk(sclk), .sdi(sdi), .sdo(sdo));

  // 200 MHz system clock
  always #2.5 pclk = ~pclk;

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask : endt

  task automatic report_and_stop();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // One APB transfer; a read notes its masked expectation
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    int n;
    n = 0;
    if (!w) expq.push_back({a == 8'h3c, m, d & m});
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("pready wait", 32'h1, 32'(n));
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // One link word in, the word sent out compared
  task automatic frame(input logic [7:0] e);
    logic [7:0] r;
    r = 8'($urandom);
    rxq.push_back(r);
    peer.xfer(r, q);
    chk("sdo", {24'h0, e}, {24'h0, q});
  endtask : frame

  // Result watcher: oldest note against each finished read
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      ent = expq.pop_front();
      chk("prdata", ent[31:0], prdata & ent[63:32]);
      chk("pslverr", 32'(ent[64]), 32'(pslverr));
    end
  end

  // Hang guard
  initial begin
    #100us;
    chk("watchdog", 32'h0, 32'h1);
    report_and_stop();
  end

  // Main sequence
  initial begin
    void'($urandom(88));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, ADDR_STAT, STAT_RST, '1);
    apb(0, 8'h3c, 32'h0, '1);
    apb(1, ADDR_CTRL, 32'h1, 32'h0);
    repeat (4) @(posedge pclk);
    apb(0, ADDR_STAT, 32'h0005_8110, '1);
    endt("reset");
    apb(1, ADDR_FCTL, 32'h0, 32'h0);
    repeat (5) begin
      txq.push_back(8'($urandom));
      apb(1, ADDR_TXD, {24'h0, txq[$]}, 32'h0);
    end
    void'(txq.pop_back());
    apb(0, ADDR_STAT, 32'h4002_0000, 32'hf0ff_0000);
    apb(1, ADDR_MASK, 32'h0004_0000, 32'h0);
    for (int c = 0; c < 4; c++) begin
      apb(1, ADDR_FCTL, c << 28, 32'h0);
      apb(0, ADDR_STAT, 32'(c == 3) << 18, 32'h0004_0000);
      repeat (2) @(posedge pclk);
      chk("irq", 32'(c == 3), 32'(irq));
    end
    endt("levels");
    apb(1, ADDR_CTRL, 32'h3, 32'h0);
    frame(txq[0]);
    repeat (40) @(posedge pclk);
    apb(0, ADDR_STAT, 32'h0100_0000, 32'h0f00_1000);
    apb(1, ADDR_CTRL, 32'h1, 32'h0);
    repeat (40) @(posedge pclk);
    apb(0, ADDR_STAT, 32'h0100_1000, 32'h0f00_1000);
    apb(0, ADDR_RXD, {24'h0, rxq.pop_front()}, '1);
    apb(0, ADDR_STAT, 32'h0000_0100, 32'h0f00_1100);
    endt("timeout");
    for (int i = 1; i < 4; i++) frame(txq[i]);
    repeat (2) frame({8{txq[3][0]}});
    void'(rxq.pop_back());
    repeat (40) @(posedge pclk);
    apb(0, ADDR_STAT, 32'h040d_9e00, 32'hffff_ff00);
    apb(1, ADDR_STAT, 32'h0008_0800, 32'h0);
    apb(0, ADDR_STAT, 32'h0, 32'h0008_0800);
    repeat (4) apb(0, ADDR_RXD, {24'h0, rxq.pop_front()}, '1);
    apb(0, ADDR_STAT, 32'h0000_0100, 32'h0f00_1f00);
    endt("overflow");
    repeat (2) apb(1, ADDR_TXD, 32'h5a, 32'h0);
    apb(1, ADDR_FCTL, 32'h3000_0002, 32'h0);
    @(posedge pclk);
    apb(0, ADDR_STAT, 32'h0080_0000, 32'h0080_0000);
    repeat (10) @(posedge pclk);
    apb(0, ADDR_STAT, 32'h0001_0000, 32'hf083_0000);
    endt("flush");
    report_and_stop();
  end
endmodule : tb_spisf_top
`default_nettype wire
